// >>> include/sdf_pkg.sv
// constants and types for the sinc3 decimation controller
package sdf_pkg;
    // ----------------------------------------
    // widths and counts
    // ----------------------------------------
    localparam int ACC_WIDTH = 24;
    localparam int WORD_WIDTH = 16;
    localparam int COUNT_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int WARMUP_WORDS = 3;
    localparam int SAMPLE_DIV = 4;
    localparam logic [ACC_WIDTH-1:0] ACC_RESET = 24'h000000;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 8'h00;
    typedef enum logic [1:0] {st_idle, st_low, st_high} sdf_phase_type;
endpackage : sdf_pkg

// >>> include/sdf_stream_if.sv
// valid/ready word stream between decimator and fifo
`timescale 1ns/1ns
interface sdf_stream_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : sdf_stream_if

// >>> verilog/sdf_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
module sdf_fifo
    import sdf_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst,
    sdf_stream_if.sink wr,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
    logic do_wr;
    logic do_rd;
    assign wr.ready = (fill != (AW+1)'(DEPTH));
    assign rd_valid = (fill != '0);
    assign rd_data = mem[rp];
    assign do_wr = wr.valid && wr.ready;
    assign do_rd = rd_valid && rd_ready;
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wp] <= wr.data;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp <= '0;
            rp <= '0;
            fill <= '0;
        end
        else
        begin
            if (do_wr)
                wp <= wp + 1'b1;
            if (do_rd)
                rp <= rp + 1'b1;
            fill <= fill + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : sdf_fifo

// >>> verilog/sdf_decimator.sv
// sinc3 decimation controller: drives sample clock, filters the bit stream
`timescale 1ns/1ns
module sdf_decimator
    import sdf_pkg::*;
#(
    parameter int DIV = SAMPLE_DIV,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bitstream_out,
    output logic sample_clock_in,
    output logic word_valid,
    input wire logic word_ready,
    output logic [WORD_WIDTH-1:0] word_data,
    output logic word_overflow
);
    initial
    begin
        if (DIV < 2 || DIV > 256 || DIV % 2 != 0) $error("divider must be even, 2 to 256");
    end
    // ----------------------------------------
    // sample clock generation
    // ----------------------------------------
    // the clock we drive out is derived from clk, so no second domain exists
    localparam int HALF = DIV / 2;
    logic [7:0] div_count;
    logic rise_en;
    logic fall_en;
    always_ff @(posedge clk)
    begin
        if (rst)
            div_count <= 8'h00;
        else if (div_count == 8'(DIV - 1))
            div_count <= 8'h00;
        else
            div_count <= div_count + 8'h01;
    end
    assign rise_en = (div_count == 8'h00) && !rst;
    assign fall_en = (div_count == 8'(HALF)) && !rst;
    always_ff @(posedge clk)
    begin
        if (rst)
            sample_clock_in <= 1'b0;
        else if (rise_en)
            sample_clock_in <= 1'b1;
        else if (fall_en)
            sample_clock_in <= 1'b0;
    end
    // ----------------------------------------
    // bit input synchroniser
    // ----------------------------------------
    logic bit_meta;
    logic filter_bit_input;
    always_ff @(posedge clk)
    begin
        bit_meta <= bitstream_out;
        filter_bit_input <= bit_meta;
    end
    // ----------------------------------------
    // integrators
    // ----------------------------------------
    // sampling near the falling edge leaves half a period of settling
    logic [ACC_WIDTH-1:0] converted_input_bit;
    logic [ACC_WIDTH-1:0] integrator_stage_one;
    logic [ACC_WIDTH-1:0] integrator_stage_two;
    logic [ACC_WIDTH-1:0] integrator_stage_three;
    assign converted_input_bit = {{(ACC_WIDTH-1){1'b0}}, filter_bit_input};
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            integrator_stage_one <= ACC_RESET;
            integrator_stage_two <= ACC_RESET;
            integrator_stage_three <= ACC_RESET;
        end
        else if (fall_en)
        begin
            integrator_stage_one <= integrator_stage_one + converted_input_bit;
            integrator_stage_two <= integrator_stage_two + integrator_stage_one;
            integrator_stage_three <= integrator_stage_three + integrator_stage_two;
        end
    end
    // ----------------------------------------
    // decimation counter
    // ----------------------------------------
    logic [COUNT_WIDTH-1:0] word_count;
    logic word_tick;
    always_ff @(posedge clk)
    begin
        if (rst)
            word_count <= COUNT_RESET;
        else if (fall_en)
            word_count <= word_count + 8'h01;
    end
    // word clock rising edge: msb goes 0 to 1, once per 256 samples
    assign word_tick = fall_en && (word_count == 8'h7f);
    // ----------------------------------------
    // differentiators
    // ----------------------------------------
    logic [ACC_WIDTH-1:0] integrator_delay;
    logic [ACC_WIDTH-1:0] differentiator_stage_one;
    logic [ACC_WIDTH-1:0] differentiator_stage_two;
    logic [ACC_WIDTH-1:0] differentiator_stage_three;
    logic [ACC_WIDTH-1:0] diff_one_delay;
    logic [ACC_WIDTH-1:0] diff_two_delay;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            integrator_delay <= ACC_RESET;
            diff_one_delay <= ACC_RESET;
            diff_two_delay <= ACC_RESET;
            differentiator_stage_one <= ACC_RESET;
            differentiator_stage_two <= ACC_RESET;
            differentiator_stage_three <= ACC_RESET;
        end
        else if (word_tick)
        begin
            differentiator_stage_one <= integrator_stage_three - integrator_delay;
            differentiator_stage_two <= differentiator_stage_one - diff_one_delay;
            differentiator_stage_three <= differentiator_stage_two - diff_two_delay;
            integrator_delay <= integrator_stage_three;
            diff_one_delay <= differentiator_stage_one;
            diff_two_delay <= differentiator_stage_two;
        end
    end
    // ----------------------------------------
    // output word and warm-up
    // ----------------------------------------
    logic [WORD_WIDTH-1:0] out_word;
    logic [1:0] warm_count;
    logic word_push;
    always_ff @(posedge clk)
    begin
        if (rst)
            out_word <= 16'h0000;
        else if (word_tick)
            out_word <= differentiator_stage_three[ACC_WIDTH-1:ACC_WIDTH-WORD_WIDTH];
    end
    // out_word lags the combs one tick; wait WARMUP_WORDS ticks before trusting it
    always_ff @(posedge clk)
    begin
        if (rst)
            warm_count <= 2'h0;
        else if (word_tick && warm_count != 2'(WARMUP_WORDS))
            warm_count <= warm_count + 2'h1;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            word_push <= 1'b0;
        else
            word_push <= word_tick && (warm_count == 2'(WARMUP_WORDS));
    end
    // ----------------------------------------
    // fifo
    // ----------------------------------------
    // the filter cannot stall, so a full fifo drops the word and flags it
    sdf_stream_if #(.WIDTH(WORD_WIDTH)) push_if ();
    assign push_if.valid = word_push;
    assign push_if.data = out_word;
    always_ff @(posedge clk)
    begin
        if (rst)
            word_overflow <= 1'b0;
        else if (word_push && !push_if.ready)
            word_overflow <= 1'b1;
    end
    logic fifo_valid;
    logic [WORD_WIDTH-1:0] fifo_data;
    logic out_take;
    assign out_take = fifo_valid && (!word_valid || word_ready);
    sdf_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(DEPTH)) u_fifo
    (
        .clk(clk),
        .rst(rst),
        .wr(push_if.sink),
        .rd_valid(fifo_valid),
        .rd_ready(out_take),
        .rd_data(fifo_data)
    );
    // output stage register so every top output comes from a flip-flop
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            word_valid <= 1'b0;
            word_data <= 16'h0000;
        end
        else if (out_take)
        begin
            word_valid <= 1'b1;
            word_data <= fifo_data;
        end
        else if (word_ready)
            word_valid <= 1'b0;
    end
endmodule : sdf_decimator

// >>> verif/sdf_decimator_assertions.sv
// port checker for the sinc3 decimator
`timescale 1ns/1ns
module sdf_decimator_assertions
    import sdf_pkg::*;
#(parameter int DIV = 2)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bitstream_out,
    input wire logic sample_clock_in,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire logic [WORD_WIDTH-1:0] word_data,
    input wire logic word_overflow
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    localparam int HALF = DIV / 2;
    int samples;
    logic stalled;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk)
    begin
        if (rst)
            samples <= 0;
        else if ($fell(sample_clock_in))
            samples <= samples + 1;
    end
    // overflow needs a stalled consumer first
    always_ff @(posedge clk)
    begin
        if (rst)
            stalled <= 1'b0;
        else if (word_valid && !word_ready)
            stalled <= 1'b1;
    end
    AST_SCK_HIGH: assert property ($rose(sample_clock_in) |-> ##HALF $fell(sample_clock_in))
        else $error("sample clock high time wrong");
    AST_SCK_LOW: assert property ($fell(sample_clock_in) |-> ##HALF $rose(sample_clock_in))
        else $error("sample clock low time wrong");
    AST_WORD_HOLD: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
        else $error("word dropped before accept");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) rst |=> !word_valid && !word_overflow
        && !sample_clock_in && word_data == 16'h0000)
        else $error("reset left state");
    AST_WARMUP: assert property (word_valid |-> samples >= 896)
        else $error("word before warm-up");
    AST_OVF_STICKY: assert property (word_overflow |=> word_overflow)
        else $error("overflow cleared");
    AST_OVF_FULL: assert property ($rose(word_overflow) |-> word_valid)
        else $error("overflow with empty buffer");
    AST_OVF_STALL: assert property (!stalled |-> !word_overflow)
        else $error("overflow without stall");
    cover property (word_valid && word_ready);
    cover property ($rose(word_overflow));
    cover property (samples == 896);
endmodule : sdf_decimator_assertions
bind sdf_decimator sdf_decimator_assertions #(.DIV(DIV)) u_chk (.clk(clk), .rst(rst),
    .bitstream_out(bitstream_out), .sample_clock_in(sample_clock_in),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data),
    .word_overflow(word_overflow));

// >>> verif/sdf_modulator_model.sv
// behavioural modulator: repeating four-bit ones pattern
`timescale 1ns/1ns
module sdf_modulator_model
(
    input wire logic rst,
    input wire logic sample_clock_in,
    input wire logic [3:0] pattern,
    output logic bitstream_out
);
    // ----------------------------------------
    // one bit per sample clock period
    // ----------------------------------------
    logic [1:0] phase;
    // launched on the rise so it is settled at the sampling fall
    always @(posedge sample_clock_in or posedge rst)
    begin
        if (rst)
        begin
            phase <= 2'h0;
            bitstream_out <= 1'b0;
        end
        else
        begin
            bitstream_out <= pattern[phase];
            phase <= phase + 2'h1;
        end
    end
endmodule : sdf_modulator_model

// >>> verif/sdf_decimator_tb.sv
// self-checking bench for the sinc3 decimator
`timescale 1ns/1ns
module sdf_decimator_tb;
    import sdf_pkg::*;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    localparam int DIV = 2;
    localparam int WORD_CLKS = 256 * DIV;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic word_ready = 1'b0;
    logic [3:0] pattern = 4'h0;
    logic bitstream_out, sample_clock_in, word_valid, word_overflow;
    logic [WORD_WIDTH-1:0] word_data, w;
    // patterns of period 4 settle to an exact share of full scale
    logic [3:0] pat [5] = '{4'h0, 4'h5, 4'h1, 4'h7, 4'hf};
    logic [15:0] expw [5] = '{16'h0000, 16'h8000, 16'h4000, 16'hc000, 16'h0000};
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0;
    always #10 clk = ~clk;
    sdf_decimator #(.DIV(DIV)) uut (.clk(clk), .rst(rst), .bitstream_out(bitstream_out),
        .sample_clock_in(sample_clock_in), .word_valid(word_valid), .word_ready(word_ready),
        .word_data(word_data), .word_overflow(word_overflow));
    sdf_modulator_model u_mod (.rst(rst), .sample_clock_in(sample_clock_in),
        .pattern(pattern), .bitstream_out(bitstream_out));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task results;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            mismatches++;
            results();
        end
    end
    task get_word;
        int n;
        n = 0;
        word_ready = 1'b1;
        @(posedge clk);
        while (word_valid !== 1'b1 && n < 4000)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 4000)
            mismatches++;
        w = word_data;
        @(negedge clk);
        word_ready = 1'b0;
    endtask : get_word
    task do_reset;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        check({13'h0000, word_valid, word_overflow, sample_clock_in}, 16'h0000);
        check(word_data, 16'h0000);
        rst = 1'b0;
    endtask : do_reset
    task t_patterns;
        for (int i = 0; i < 5; i++)
        begin
            pattern = pat[i];
            repeat (6) get_word();
            t0 = cyc;
            get_word();
            check(w, expw[i]);
            check(16'(cyc - t0), 16'(WORD_CLKS));
        end
    endtask : t_patterns
    // stall a whole number of word periods so the drain ends well before the next word
    task t_overflow;
        pattern = 4'h5;
        repeat (7) get_word();
        repeat (10 * WORD_CLKS) @(negedge clk);
        check({15'h0000, word_overflow}, 16'h0001);
        // the output register holds one word beside the full fifo, so nine drain
        for (int i = 0; i < FIFO_DEPTH + 1; i++)
        begin
            get_word();
            check(w, 16'h8000);
        end
        check({15'h0000, word_valid}, 16'h0000);
    endtask : t_overflow
    initial
    begin
        rst = 1'b1;
        do_reset();
        t_patterns();
        t_overflow();
        do_reset();
        get_word();
        check({15'h0000, word_overflow}, 16'h0000);
        results();
    end
endmodule : sdf_decimator_tb
